//--- verilog/wdt_regs.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  watchdog timeout unit.
  Assumes it is included by bare name from the watchdog top module.
*/
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH

// register addresses on the 16-bit bus
`define WDT_SVC_ADDR    16'hffff
`define WDT_CFG_ADDR    16'hff80
`define WDT_STAT_ADDR   16'hff81
`define WDT_MASK_ADDR   16'hff82
`define WDT_CAUSE_ADDR  16'hff83
`define WDT_CNT_ADDR    16'hff84

// config_register_one fields
`define WDT_CFG_RATE    0
`define WDT_CFG_DIS     1
`define WDT_CFG_STOPD   2
`define WDT_CFG_MASK    8'h07
`define WDT_CFG_RST     8'h00

// event status / mask fields
`define WDT_EV_SVC      0
`define WDT_EV_ILL      1
`define WDT_EV_MON      2
`define WDT_EV_MASK     8'h07
`define WDT_CAUSE_BIT   0

// timeout limits of the 18-bit chain: 2^13-2^4 and 2^18-2^4
`define WDT_SHORT_TOP   18'h01ff0
`define WDT_LONG_TOP    18'h3fff0

// service keeps prescaler bits 3..0, clears stages 12..5 (bits 11..4)
`define WDT_PRE_KEEP    12'h00f

// reset pulse of 32 oscillator cycles, last index 31
`define WDT_PULSE_LAST  5'd31
// power-on prescaler clear after 4096 oscillator cycles, last index 4095
`define WDT_POR_LAST    12'hfff

// rates used to derive the oscillator enable
`define WDT_CLK_HZ      100000000
`define WDT_OSC_HZ      47000

`endif

//--- verilog/wdt_pkg.sv
/*
  Types of the watchdog timeout unit: bus request carrier, run mode and
  the packed state record of the top module.
  Assumes the register header supplies all numeric constants.
*/
package wdt_pkg;

  // register bus request from the cpu side
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic        re;
  } wdt_bus_req_s;

  // run mode of the timeout engine
  typedef enum logic [0:0] {
    WDT_RUN,
    WDT_FIRE
  } wdt_mode_e;

  // complete state of the top module
  typedef struct packed {
    wdt_mode_e   mode;
    logic [15:0] div;
    logic [11:0] pre;
    logic [5:0]  cnt;
    logic [4:0]  pulse;
    logic [11:0] por_cnt;
    logic        por_done;
    logic        svc_pend;
    logic [7:0]  cfg;
    logic [7:0]  stat;
    logic [7:0]  mask;
    logic        cause;
    logic        mon_tst;
    logic        mon_blank;
    logic        irq_s1;
    logic        irq_s2;
    logic        rst_s1;
    logic        rst_s2;
    logic        ill_rst;
    logic        irq;
    logic        pin_lvl;
    logic        pin_oe;
    logic [7:0]  rdata;
  } wdt_state_s;

endpackage : wdt_pkg

//--- verilog/wdt_top.sv
/*
  Watchdog timeout unit: 12-bit prescaler and 6-bit counter on the
  oscillator enable, service location, configuration, monitor and break
  lockouts, reset pulse on the open-drain reset pin, event interrupt.
  Assumes a 100 MHz clk_i, same-clock cpu strobes and mode inputs, and
  test-voltage detectors that arrive asynchronously from pins.
*/
// Local design decision: the address-and-strobe port.
`include "wdt_regs.svh"

module wdt_top #(
  parameter int OSC_DIV = `WDT_CLK_HZ / `WDT_OSC_HZ
) (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_b_i,
  // register bus
  input  wire wdt_pkg::wdt_bus_req_s bus_i,
  output logic [7:0]              rdata_o,
  // reset vector low byte shared with the service location
  input  wire logic [7:0]         vec_lo_i,
  // system mode inputs, same clock
  input  wire logic               int_rst_i,
  input  wire logic               stop_mode_i,
  input  wire logic               stop_exec_i,
  input  wire logic               vec_fetch_i,
  input  wire logic               mon_entry_i,
  input  wire logic               blank_vec_i,
  input  wire logic               break_i,
  // test-voltage detectors from pins, asynchronous
  input  wire logic               irq_tst_i,
  input  wire logic               rst_tst_i,
  // reset outputs
  output logic                    wdt_rst_req_o,
  output logic                    rst_pin_o,
  output logic                    rst_pin_oe_o,
  output logic                    cause_o,
  output logic                    illegal_rst_o,
  // event interrupt
  output logic                    irq_o
);
  import wdt_pkg::*;

  wdt_state_s s_reg;
  wdt_state_s s_next;

  // timeout limit of the 18-bit chain for a given rate select
  function automatic logic [17:0] wdt_limit(input logic rate);
    wdt_limit = rate ? `WDT_SHORT_TOP : `WDT_LONG_TOP;
  endfunction : wdt_limit

  // address match for a register strobe
  function automatic logic wdt_hit(input logic        strobe,
                                   input logic [15:0] addr,
                                   input logic [15:0] target);
    wdt_hit = strobe & (addr == target);
  endfunction : wdt_hit

  logic        tick_raw;
  logic        tick_run;
  logic        active;
  logic        pre_clr;
  logic [17:0] chain;
  logic [17:0] chain_inc;
  logic [7:0]  ev;
  logic [7:0]  stat_w1c;
  logic        cause_set;
  logic        cause_w1c;
  logic        svc_wr;

  // next-state logic of the whole unit
  always_comb begin
    s_next    = s_reg;
    ev        = 8'h00;
    stat_w1c  = 8'h00;
    cause_set = 1'b0;
    cause_w1c = 1'b0;
    pre_clr   = 1'b0;

    // two-stage synchronisers for the pin detectors
    s_next.irq_s1 = irq_tst_i;
    s_next.irq_s2 = s_reg.irq_s1;
    s_next.rst_s1 = rst_tst_i;
    s_next.rst_s2 = s_reg.rst_s1;

    // oscillator enable derived from the system clock
    tick_raw = (s_reg.div == 16'h0000);
    if (tick_raw) begin
      s_next.div = 16'(OSC_DIV - 1);
    end else begin
      s_next.div = s_reg.div - 16'h0001;
    end
    // stop mode removes the oscillator from the chain; wait mode does not
    tick_run = tick_raw & ~stop_mode_i;

    // monitor lockouts
    if (mon_entry_i) begin
      if (s_reg.irq_s2) begin
        s_next.mon_tst = 1'b1;
        ev[`WDT_EV_MON] = 1'b1;
      end else if (blank_vec_i) begin
        s_next.mon_blank = 1'b1;
        ev[`WDT_EV_MON] = 1'b1;
      end
    end else if (s_reg.mon_tst && !s_reg.irq_s2 && !s_reg.rst_s2) begin
      s_next.mon_tst = 1'b0;
    end

    // overall enable from config, monitor and break
    active = ~s_reg.cfg[`WDT_CFG_DIS]
           & ~s_reg.mon_tst
           & ~s_reg.mon_blank
           & ~(break_i & s_reg.rst_s2);

    // stop instruction: illegal opcode reset when stop is disabled
    s_next.ill_rst = 1'b0;
    if (stop_exec_i) begin
      if (s_reg.cfg[`WDT_CFG_STOPD]) begin
        s_next.ill_rst = 1'b1;
        ev[`WDT_EV_ILL] = 1'b1;
      end else begin
        pre_clr = 1'b1;
      end
    end
    if (stop_mode_i) begin
      pre_clr = 1'b1;
    end
    if (vec_fetch_i) begin
      pre_clr = 1'b1;
    end

    // power-on prescaler clear after the start-up count
    if (!s_reg.por_done && tick_raw) begin
      if (s_reg.por_cnt == `WDT_POR_LAST) begin
        s_next.por_done = 1'b1;
        pre_clr = 1'b1;
      end else begin
        s_next.por_cnt = s_reg.por_cnt + 12'h001;
      end
    end

    // 18-bit chain: counter on top of prescaler
    chain     = {s_reg.cnt, s_reg.pre};
    chain_inc = chain + 18'h00001;

    // service write is held until the next oscillator tick
    svc_wr = wdt_hit(bus_i.we, bus_i.addr, `WDT_SVC_ADDR);

    unique case (s_reg.mode)
      WDT_RUN: begin
        if (tick_run) begin
          if (s_reg.svc_pend) begin
            s_next.cnt = 6'h00;
            s_next.pre = s_reg.pre & `WDT_PRE_KEEP;
            s_next.svc_pend = 1'b0;
            ev[`WDT_EV_SVC] = 1'b1;
          end else if (!active) begin
            s_next.cnt = 6'h00;
            s_next.pre = 12'h000;
          end else if (chain_inc == wdt_limit(s_reg.cfg[`WDT_CFG_RATE])) begin
            // timeout goes to the reset pin and the cause flag, never to irq_o
            s_next.mode    = WDT_FIRE;
            s_next.cnt     = 6'h00;
            s_next.pre     = 12'h000;
            s_next.pulse   = 5'd0;
            s_next.pin_oe  = 1'b1;
            s_next.pin_lvl = 1'b0;
            cause_set      = 1'b1;
          end else begin
            s_next.cnt = chain_inc[17:12];
            s_next.pre = chain_inc[11:0];
          end
        end
      end
      WDT_FIRE: begin
        // reset pin held low for the pulse length on the raw oscillator
        s_next.cnt = 6'h00;
        s_next.pre = 12'h000;
        s_next.svc_pend = 1'b0;
        if (tick_raw) begin
          if (s_reg.pulse == `WDT_PULSE_LAST) begin
            s_next.mode    = WDT_RUN;
            s_next.pin_oe  = 1'b0;
            s_next.pin_lvl = 1'b1;
          end else begin
            s_next.pulse = s_reg.pulse + 5'd1;
          end
        end
      end
    endcase

    // prescaler clears from stop, vector fetch and power-on
    if (pre_clr) begin
      s_next.pre = 12'h000;
    end

    // a new service write arms the pending clear
    if (svc_wr && s_reg.mode == WDT_RUN) begin
      s_next.svc_pend = 1'b1;
    end

    // internal reset clears chain and rate select
    if (int_rst_i) begin
      s_next.pre      = 12'h000;
      s_next.cnt      = 6'h00;
      s_next.svc_pend = 1'b0;
      s_next.cfg[`WDT_CFG_RATE] = 1'b0;
    end

    // register writes
    if (wdt_hit(bus_i.we, bus_i.addr, `WDT_CFG_ADDR) && !int_rst_i) begin
      s_next.cfg = bus_i.wdata & `WDT_CFG_MASK;
    end
    if (wdt_hit(bus_i.we, bus_i.addr, `WDT_STAT_ADDR)) begin
      stat_w1c = bus_i.wdata & `WDT_EV_MASK;
    end
    if (wdt_hit(bus_i.we, bus_i.addr, `WDT_MASK_ADDR)) begin
      s_next.mask = bus_i.wdata & `WDT_EV_MASK;
    end
    if (wdt_hit(bus_i.we, bus_i.addr, `WDT_CAUSE_ADDR)) begin
      cause_w1c = bus_i.wdata[`WDT_CAUSE_BIT];
    end

    // sticky flags: a set in the clearing cycle wins
    s_next.stat  = (s_reg.stat & ~stat_w1c) | ev;
    s_next.cause = (s_reg.cause & ~cause_w1c) | cause_set;
    s_next.irq   = |(s_next.stat & s_next.mask);

    // read data, valid in the cycle after the read strobe
    s_next.rdata = 8'h00;
    if (bus_i.re) begin
      unique case (bus_i.addr)
        `WDT_SVC_ADDR:   s_next.rdata = vec_lo_i;
        `WDT_CFG_ADDR:   s_next.rdata = s_reg.cfg;
        `WDT_STAT_ADDR:  s_next.rdata = s_reg.stat;
        `WDT_MASK_ADDR:  s_next.rdata = s_reg.mask;
        `WDT_CAUSE_ADDR: s_next.rdata = {7'h00, s_reg.cause};
        `WDT_CNT_ADDR:   s_next.rdata = {2'h0, s_reg.cnt};
        default:         s_next.rdata = 8'h00;
      endcase
    end
  end

  // single state register, async active-low reset acts as power-on
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_reg           <= '0;
      s_reg.mode      <= WDT_RUN;
      s_reg.cfg       <= `WDT_CFG_RST;
      s_reg.pin_lvl   <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  assign rdata_o       = s_reg.rdata;
  assign wdt_rst_req_o = s_reg.pin_oe;
  assign rst_pin_o     = s_reg.pin_lvl;
  assign rst_pin_oe_o  = s_reg.pin_oe;
  assign cause_o       = s_reg.cause;
  assign illegal_rst_o = s_reg.ill_rst;
  assign irq_o         = s_reg.irq;

endmodule : wdt_top

//--- testbench/wdt_top_props.sv
/* Checker of the watchdog top ports: reset pulse, read data, events.
   Assumes it is bound into wdt_top and receives its OSC_DIV. */
`include "wdt_regs.svh"
module wdt_top_props #(
  parameter int OSC_DIV = 2
) (
  // clock and reset
  input wire logic                  clk_i,
  input wire logic                  rst_b_i,
  // bus and mode inputs
  input wire wdt_pkg::wdt_bus_req_s bus_i,
  input wire logic [7:0]            vec_lo_i,
  input wire logic                  stop_mode_i,
  input wire logic                  break_i,
  input wire logic                  rst_tst_i,
  // outputs under watch
  input wire logic [7:0]            rdata_o,
  input wire logic                  wdt_rst_req_o,
  input wire logic                  rst_pin_o,
  input wire logic                  rst_pin_oe_o,
  input wire logic                  cause_o,
  input wire logic                  illegal_rst_o,
  input wire logic                  irq_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import wdt_pkg::*;
  logic [15:0] plen_reg;
  // length of the running reset pulse in clocks
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      plen_reg <= 16'h0000;
    end else begin
      plen_reg <= wdt_rst_req_o ? plen_reg + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // reset pulse shape and cause
  chk_pin_drive: assert property (
    rst_pin_oe_o == wdt_rst_req_o && rst_pin_o == !rst_pin_oe_o)
    else $error("reset pin drive disagrees with pulse");
  chk_cause_set: assert property ($rose(wdt_rst_req_o) |-> cause_o)
    else $error("cause flag missing at pulse start");
  chk_pulse_len: assert property (
    $fell(wdt_rst_req_o) |-> plen_reg == 32 * OSC_DIV)
    else $error("reset pulse length wrong");
  chk_irq_quiet: assert property (
    $rose(wdt_rst_req_o) |-> $stable(irq_o))
    else $error("timeout moved the interrupt");
  // service location read, illegal reset width
  chk_rd_vector: assert property (
    bus_i.re && bus_i.addr == `WDT_SVC_ADDR |=> rdata_o == $past(vec_lo_i))
    else $error("service read not the vector byte");
  chk_ill_pulse: assert property (illegal_rst_o |=> !illegal_rst_o)
    else $error("illegal reset longer than one cycle");
  // lockouts keep the pulse away
  chk_stop_frz: assert property (
    stop_mode_i && $past(stop_mode_i) |-> !$rose(wdt_rst_req_o))
    else $error("timeout while stopped");
  chk_break_off: assert property (
    $past(break_i) && $past(rst_tst_i, 2) && $past(rst_tst_i, 3) &&
    $past(rst_tst_i, 4) |-> !$rose(wdt_rst_req_o))
    else $error("timeout during break lockout");
  cover property ($rose(wdt_rst_req_o));
  cover property (illegal_rst_o);
  cover property ($rose(irq_o));
endmodule : wdt_top_props
bind wdt_top wdt_top_props #(.OSC_DIV(OSC_DIV)) wdt_top_props_inst (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .bus_i(bus_i), .vec_lo_i(vec_lo_i),
  .stop_mode_i(stop_mode_i), .break_i(break_i), .rst_tst_i(rst_tst_i),
  .rdata_o(rdata_o), .wdt_rst_req_o(wdt_rst_req_o), .rst_pin_o(rst_pin_o),
  .rst_pin_oe_o(rst_pin_oe_o), .cause_o(cause_o),
  .illegal_rst_o(illegal_rst_o), .irq_o(irq_o));

//--- testbench/wdt_cpu_model.sv
/* Cpu software that services the watchdog once a period.
   Assumes the bench routes its bus to the watchdog while kick_en_i. */
module wdt_cpu_model #(
  parameter int PERIOD = 4000
) (
  // clock and reset
  input  wire logic            clk_i,
  input  wire logic            rst_b_i,
  // control and bus
  input  wire logic            kick_en_i,
  output wdt_pkg::wdt_bus_req_s bus_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import wdt_pkg::*;
  int gap;
  // one-cycle write of any value to the service location
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gap <= 0;
      bus_o <= '0;
    end else begin
      // each field is written once per edge: a kick, or the strobe dropped
      if (kick_en_i && gap >= PERIOD) begin
        gap <= 0;
        bus_o <= '{16'hffff, 8'($urandom), 1'b1, 1'b0};
      end else begin
        gap <= gap + 1;
        bus_o.we <= 1'b0;
      end
    end
  end
endmodule : wdt_cpu_model

//--- testbench/watchdog_timeout_unit_test.sv
/* Self-checking bench of the watchdog timeout unit.
   Assumes the top, its checker and the cpu model are compiled first. */
`include "wdt_regs.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
  $display("ERROR %0t got %h want %h", $time, a, e); end end
module watchdog_timeout_unit_test;
  timeunit 1ns;
  timeprecision 100ps;
  import wdt_pkg::*;
  localparam int D = 2;
  logic         clk_i, rst_b_i, kick_en, int_rst, stop_mode, stop_exec;
  logic         brk, rst_tst, rst_req, pin, pin_oe, cause, ill, irq;
  logic         vec_fetch, mon_entry, blank, irq_tst;
  logic [7:0]   vec_lo, rdata, v;
  wdt_bus_req_s tb_bus, cpu_bus, bus;
  int           n_mismatch, cmp_count, cyc, n;
  assign bus = kick_en ? cpu_bus : tb_bus;
  wdt_top #(.OSC_DIV(D)) wdt_top_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .bus_i(bus), .rdata_o(rdata), .vec_lo_i(vec_lo), .int_rst_i(int_rst),
    .stop_mode_i(stop_mode), .stop_exec_i(stop_exec), .vec_fetch_i(vec_fetch),
    .mon_entry_i(mon_entry), .blank_vec_i(blank), .break_i(brk),
    .irq_tst_i(irq_tst), .rst_tst_i(rst_tst), .wdt_rst_req_o(rst_req),
    .rst_pin_o(pin), .rst_pin_oe_o(pin_oe), .cause_o(cause),
    .illegal_rst_o(ill), .irq_o(irq));
  wdt_cpu_model #(.PERIOD(4000)) wdt_cpu_model_inst (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .kick_en_i(kick_en), .bus_o(cpu_bus));
  // bus write and read cycles
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i) tb_bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_i) tb_bus.we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a);
    @(posedge clk_i) tb_bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_i) tb_bus.re <= 1'b0;
    #1 v = rdata;
  endtask : rd
  // count pulse cycles seen over a window
  task automatic quiet(input int c);
    n = 0;
    repeat (c) @(negedge clk_i) if (rst_req !== 1'b0) n++;
    // hand back on a rising edge so the caller drives inputs there
    @(posedge clk_i);
  endtask : quiet
  // expected span from a prescaler clear to timeout, with some slack
  function automatic bit in_win(input int c, input int top);
    return c >= (top - 16) * D - 16 && c <= (top + 2) * D;
  endfunction : in_win
  task automatic conclude();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // cut a hung run short
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 100000) begin
      n_mismatch++;
      conclude();
    end
  end
  initial begin
    {rst_b_i, kick_en, int_rst, stop_mode, stop_exec, brk, rst_tst} = '0;
    {vec_fetch, mon_entry, blank, irq_tst} = '0;
    tb_bus = '0;
    vec_lo = 8'h00;
    void'($urandom(41));
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(`WDT_CFG_ADDR); `CHK(v, 8'h00)
    rd(16'h1234); `CHK(v, 8'h00)
    repeat (4) begin
      @(posedge clk_i) vec_lo <= 8'($urandom);
      rd(`WDT_SVC_ADDR); `CHK(v, vec_lo)
    end
    // service event sets its flag while masked, then unmasking raises the interrupt
    wr(`WDT_SVC_ADDR, 8'($urandom));
    repeat (3 * D) @(posedge clk_i);
    #1 `CHK(irq, 1'b0)
    rd(`WDT_STAT_ADDR); `CHK(v[0], 1'b1)
    wr(`WDT_MASK_ADDR, 8'h07);
    repeat (2) @(posedge clk_i);
    #1 `CHK(irq, 1'b1)
    // stop instruction while disabled gives illegal reset
    wr(`WDT_CFG_ADDR, 8'h04);
    @(posedge clk_i) stop_exec <= 1'b1;
    @(posedge clk_i) stop_exec <= 1'b0;
    #1 `CHK(ill, 1'b1)
    rd(`WDT_STAT_ADDR); `CHK(v[2:0], 3'b011)
    wr(`WDT_STAT_ADDR, 8'h07);
    repeat (2) @(posedge clk_i);
    #1 `CHK(irq, 1'b0)
    // internal reset drops the rate select
    wr(`WDT_CFG_ADDR, 8'h01);
    @(posedge clk_i) int_rst <= 1'b1;
    @(posedge clk_i) int_rst <= 1'b0;
    rd(`WDT_CFG_ADDR); `CHK(v[0], 1'b0)
    // partner services in time: no reset
    wr(`WDT_CFG_ADDR, 8'h01);
    kick_en <= 1'b1;
    quiet(17500); `CHK(n, 0)
    kick_en <= 1'b0;
    wr(`WDT_SVC_ADDR, 8'ha5);
    repeat (3 * D) @(posedge clk_i);
    wr(`WDT_STAT_ADDR, 8'h07);
    // a vector fetch midway restarts the span from a cleared prescaler
    repeat (2000) @(posedge clk_i);
    vec_fetch <= 1'b1;
    @(posedge clk_i) vec_fetch <= 1'b0;
    n = 0;
    while (rst_req !== 1'b1 && n < 20000) @(negedge clk_i) n++;
    `CHK(in_win(n, `WDT_SHORT_TOP), 1'b1)
    `CHK({pin, pin_oe, cause, irq}, 4'b0110)
    n = 0;
    while (rst_req === 1'b1 && n < 200) @(negedge clk_i) n++;
    `CHK(n, 32 * D)
    rd(`WDT_CAUSE_ADDR); `CHK(v[0], 1'b1)
    // disable bit, break lockout, stop mode
    wr(`WDT_CFG_ADDR, 8'h03);
    quiet(16500); `CHK(n, 0)
    brk <= 1'b1;
    rst_tst <= 1'b1;
    wr(`WDT_CFG_ADDR, 8'h01);
    quiet(16500); `CHK(n, 0)
    stop_mode <= 1'b1;
    brk <= 1'b0;
    rst_tst <= 1'b0;
    quiet(16500); `CHK(n, 0)
    // monitor entry with the irq test voltage, then with blank vectors
    irq_tst <= 1'b1;
    repeat (3) @(posedge clk_i);
    mon_entry <= 1'b1;
    @(posedge clk_i) mon_entry <= 1'b0;
    rd(`WDT_STAT_ADDR); `CHK(v[2], 1'b1)
    @(posedge clk_i) irq_tst <= 1'b0;
    wr(`WDT_STAT_ADDR, 8'h07);
    blank <= 1'b1;
    repeat (2) @(posedge clk_i);
    mon_entry <= 1'b1;
    @(posedge clk_i) mon_entry <= 1'b0;
    rd(`WDT_STAT_ADDR); `CHK(v[2], 1'b1)
    conclude();
  end
endmodule : watchdog_timeout_unit_test
